// file: timer_channel_one_capture_compare.sv
// Channel one capture/compare, 16-bit counter and count read-back behind AXI4-Lite
//
// Overview of operation
// - Capture/compare per select bit in free-run; capture in pulse-width; else compare.
// - Channel one register readable while running, writable except in pulse-width, whole 16-bit word only.
// - Channel one register holds zero after reset.
// - Compare writes accepted with counter running; value moves to shadow buffer.
// - Counter equal to shadow buffer raises the match interrupt request.
// - On match with output enabled, the output pin level inverts.
// - Free-run capture copies the count on each valid capture edge.
// - Pulse-width mode: valid edge latches count and clears counter to zero.
// - A read colliding with a capture still returns a consistent value.
// - Anytime writes in most modes, batch in trigger/PWM, none in pulse-width.
// - Read-back register is read-only, 16-bit, live count while enabled.
// - Read-back holds zero while counter disabled, also after reset.
// - On enable, counter wraps all ones to zero on count clock, then counts up.
module timer_channel_one_capture_compare
    import timer_cc1_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              clkEn,
    input  wire logic              countTick,
    input  wire logic              captureInput,
    output logic                   outputPin,
    output logic                   matchInterrupt,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [AXI_W-1:0]  wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [AXI_W-1:0]       rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready
);

    ////////////////////////////////////////////////////////////////////////
    // State
    ctrl_type          ctrl_q;
    logic [CNT_W-1:0]  counter_q;
    logic [CNT_W-1:0]  counter_d;
    logic [CNT_W-1:0]  capCmp_q;
    logic [CNT_W-1:0]  shadowBuf_q;
    logic [CNT_W-1:0]  counterReadback_q;
    logic              capPrev_q;
    logic              outPin_q;
    logic              matchIrq_q;
    logic              awHeld_q;
    logic              wHeld_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic [AXI_W-1:0]  wData_q;
    logic [3:0]        wStrb_q;
    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [AXI_W-1:0]  rdata_q;
    logic [1:0]        rresp_q;

    // Decoded conditions
    logic wrDo;
    logic wrHalfOk;
    logic wrCapCmp;
    logic wrCtrl;
    logic [1:0] wrResp;
    logic captureActive;
    logic batchMode;
    logic edgeHit;
    logic capEvent;
    logic pwClear;
    logic tickStep;
    logic boundary;
    logic matchHit;

    ////////////////////////////////////////////////////////////////////////
    // Mode decoding
    always_comb begin
        // Select bit only matters in free-run
        captureActive = (ctrl_q.mode == MODE_PULSEW) ||
                        (ctrl_q.mode == MODE_FREERUN && ctrl_q.captureSelect);
        batchMode = (ctrl_q.mode == MODE_EXTTRIG) || (ctrl_q.mode == MODE_PWM);
    end

    // Capture edge detection; input is already synchronous
    always_comb begin
        unique case (ctrl_q.edgeSel)
            EDGE_RISE: edgeHit = captureInput & ~capPrev_q;
            EDGE_FALL: edgeHit = ~captureInput & capPrev_q;
            EDGE_BOTH: edgeHit = captureInput ^ capPrev_q;
            EDGE_NONE: edgeHit = 1'b0;
        endcase
        capEvent = ctrl_q.counterEnable && captureActive && edgeHit;
        pwClear  = capEvent && (ctrl_q.mode == MODE_PULSEW);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            capPrev_q <= 1'b0;
        end else if (clkEn) begin
            capPrev_q <= captureInput;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter: idles at all ones, wraps to zero on first tick
    always_comb begin
        tickStep = ctrl_q.counterEnable && countTick;
        if (!ctrl_q.counterEnable) begin
            counter_d = CNT_IDLE;
        end else if (pwClear) begin
            counter_d = CNT_ZERO;
        end else if (countTick) begin
            counter_d = counter_q + CNT_STEP;
        end else begin
            counter_d = counter_q;
        end
        boundary = tickStep && !pwClear && (counter_d == CNT_ZERO);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            counter_q <= CNT_IDLE;
        end else if (clkEn) begin
            counter_q <= counter_d;
        end
    end

    // Read-back forced to zero while stopped, hiding the all-ones idle value
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            counterReadback_q <= CNT_ZERO;
        end else if (clkEn) begin
            counterReadback_q <= ctrl_q.counterEnable ? counter_d : CNT_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write decode; channel one takes whole 16-bit words only, control needs only byte lane 0
    always_comb begin
        wrDo     = awHeld_q && wHeld_q && !bvalid_q;
        wrHalfOk = (wStrb_q[1:0] == STRB_HALF);
        wrCapCmp = wrDo && wrHalfOk && (awAddr_q == ADDR_CHANNEL_ONE_CC);
        wrCtrl   = wrDo && wStrb_q[0] && (awAddr_q == ADDR_TIMER_CTRL);
        if (wrCapCmp || wrCtrl) begin
            wrResp = RESP_OKAY;
        end else begin
            wrResp = RESP_SLVERR;
        end
    end

    // Control register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (clkEn && wrCtrl) begin
            ctrl_q <= ctrl_type'(wData_q[CTRL_W-1:0]);
        end
    end

    // Channel one register; capture wins over a colliding write
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            capCmp_q <= CCR_RESET;
        end else if (clkEn) begin
            if (capEvent) begin
                capCmp_q <= counter_q;
            end else if (wrCapCmp && ctrl_q.mode != MODE_PULSEW) begin
                capCmp_q <= wData_q[CNT_W-1:0];
            end
        end
    end

    // Shadow buffer: tracks while stopped, immediate or at boundary while running
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            shadowBuf_q <= CCR_RESET;
        end else if (clkEn) begin
            if (!ctrl_q.counterEnable) begin
                shadowBuf_q <= capCmp_q;
            end else if (batchMode) begin
                if (boundary) begin
                    shadowBuf_q <= capCmp_q;
                end
            end else if (wrCapCmp && !captureActive) begin
                shadowBuf_q <= wData_q[CNT_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare match against the count about to be shown
    always_comb begin
        matchHit = tickStep && !pwClear && !captureActive && (counter_d == shadowBuf_q);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            matchIrq_q <= 1'b0;
        end else if (clkEn) begin
            matchIrq_q <= matchHit;
        end
    end

    // Pin toggles only when enabled; level is kept otherwise
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            outPin_q <= 1'b0;
        end else if (clkEn && matchHit && ctrl_q.outEnable) begin
            outPin_q <= ~outPin_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write address channel, held until the response is taken
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            awHeld_q  <= 1'b0;
            awready_q <= 1'b1;
            awAddr_q  <= '0;
        end else if (clkEn) begin
            if (awvalid && awready_q) begin
                awHeld_q  <= 1'b1;
                awready_q <= 1'b0;
                awAddr_q  <= awaddr;
            end else if (wrDo) begin
                awHeld_q <= 1'b0;
            end else if (bvalid_q && bready) begin
                awready_q <= 1'b1;
            end
        end
    end

    // Write data channel
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wHeld_q  <= 1'b0;
            wready_q <= 1'b1;
            wData_q  <= '0;
            wStrb_q  <= '0;
        end else if (clkEn) begin
            if (wvalid && wready_q) begin
                wHeld_q  <= 1'b1;
                wready_q <= 1'b0;
                wData_q  <= wdata;
                wStrb_q  <= wstrb;
            end else if (wrDo) begin
                wHeld_q <= 1'b0;
            end else if (bvalid_q && bready) begin
                wready_q <= 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (clkEn) begin
            if (wrDo) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wrResp;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read channel; one word latched per request, so a capture in the
    // same cycle cannot tear it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else if (clkEn) begin
            if (arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rresp_q   <= RESP_OKAY;
                rdata_q   <= '0;
                unique case (araddr)
                    ADDR_CHANNEL_ONE_CC: rdata_q[CNT_W-1:0] <= capCmp_q;
                    ADDR_COUNTER_RB: rdata_q[CNT_W-1:0] <= counterReadback_q;
                    ADDR_TIMER_CTRL: rdata_q[CTRL_W-1:0] <= ctrl_q;
                    default: rresp_q <= RESP_SLVERR;
                endcase
            end else if (rvalid_q && rready) begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // Outputs straight from flops
    assign outputPin      = outPin_q;
    assign matchInterrupt = matchIrq_q;
    assign awready        = awready_q;
    assign wready         = wready_q;
    assign bvalid         = bvalid_q;
    assign bresp          = bresp_q;
    assign arready        = arready_q;
    assign rvalid         = rvalid_q;
    assign rdata          = rdata_q;
    assign rresp          = rresp_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    property p_ccr_reset;
        $fell(sys_rst) |-> capCmp_q == CCR_RESET;
    endproperty
    a_ccr_reset: assert property (p_ccr_reset) else $error("channel one not zero after reset");

    property p_freerun_capture;
        (clkEn && capEvent && ctrl_q.mode == MODE_FREERUN) |=> capCmp_q == $past(counter_q);
    endproperty
    a_freerun_capture: assert property (p_freerun_capture) else $error("capture missed");

    property p_pw_clear;
        (clkEn && pwClear) |=> (counter_q == CNT_ZERO) && (capCmp_q == $past(counter_q));
    endproperty
    a_pw_clear: assert property (p_pw_clear) else $error("pulse width clear missed");

    property p_match_irq;
        (clkEn && ctrl_q.counterEnable && countTick && !captureActive && !pwClear
            && counter_d == shadowBuf_q) |=> matchIrq_q;
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match request missing");

    property p_pin_toggle;
        (clkEn && matchHit && ctrl_q.outEnable) |=> outPin_q != $past(outPin_q);
    endproperty
    a_pin_toggle: assert property (p_pin_toggle) else $error("output pin did not invert");

    property p_rb_zero;
        (clkEn && !ctrl_q.counterEnable) ##1 !ctrl_q.counterEnable |-> counterReadback_q == CNT_ZERO;
    endproperty
    a_rb_zero: assert property (p_rb_zero) else $error("read-back not zero while stopped");

    property p_rb_readonly;
        (clkEn && wrDo && awAddr_q == ADDR_COUNTER_RB) |=> bvalid_q && bresp_q == RESP_SLVERR;
    endproperty
    a_rb_readonly: assert property (p_rb_readonly) else $error("read-back write accepted");

    property p_half_word;
        (clkEn && wrDo && !wrHalfOk && !capEvent) |=> $stable(capCmp_q);
    endproperty
    a_half_word: assert property (p_half_word) else $error("partial write changed register");

    property p_batch_hold;
        (clkEn && ctrl_q.counterEnable && batchMode && !boundary) |=> $stable(shadowBuf_q);
    endproperty
    a_batch_hold: assert property (p_batch_hold) else $error("shadow moved off boundary");

    property p_anytime_load;
        (clkEn && ctrl_q.counterEnable && !batchMode && !captureActive && wrCapCmp)
            |=> shadowBuf_q == $past(wData_q[CNT_W-1:0]);
    endproperty
    a_anytime_load: assert property (p_anytime_load) else $error("shadow not loaded");

    property p_wrap_start;
        (clkEn && tickStep && !pwClear && counter_q == CNT_IDLE) |=> counter_q == CNT_ZERO;
    endproperty
    a_wrap_start: assert property (p_wrap_start) else $error("counter did not wrap to zero");

endmodule

// file: timer_cc1_pkg.sv
// Constants and types shared by the channel one capture/compare block
package timer_cc1_pkg;

    // Bus and data widths
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned AXI_W  = 32;
    localparam int unsigned CNT_W  = 16;

    // Printed offsets kept as register indices; byte address is four times the index
    localparam logic [31:0] IDX_CHANNEL_ONE_CC = 32'hFFFF_F5A8;
    localparam logic [31:0] IDX_COUNTER_RB     = 32'hFFFF_F5AA;
    localparam logic [31:0] IDX_TIMER_CTRL     = 32'hFFFF_F5AC;
    localparam logic [ADDR_W-1:0] ADDR_CHANNEL_ONE_CC = ADDR_W'(IDX_CHANNEL_ONE_CC << 2);
    localparam logic [ADDR_W-1:0] ADDR_COUNTER_RB     = ADDR_W'(IDX_COUNTER_RB << 2);
    localparam logic [ADDR_W-1:0] ADDR_TIMER_CTRL     = ADDR_W'(IDX_TIMER_CTRL << 2);

    // Reset and special counter values
    localparam logic [CNT_W-1:0] CCR_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_IDLE  = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_STEP  = 16'h0001;

    // Operating mode codes
    localparam logic [2:0] MODE_INTERVAL = 3'h0;
    localparam logic [2:0] MODE_EVENT    = 3'h1;
    localparam logic [2:0] MODE_EXTTRIG  = 3'h2;
    localparam logic [2:0] MODE_ONESHOT  = 3'h3;
    localparam logic [2:0] MODE_PWM      = 3'h4;
    localparam logic [2:0] MODE_FREERUN  = 3'h5;
    localparam logic [2:0] MODE_PULSEW   = 3'h6;

    // Capture edge selection
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Bus responses and strobe patterns
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] STRB_HALF   = 2'h3;

    // Control register layout, bit 0 is the counter-enable bit
    typedef struct packed {
        logic [1:0] edgeSel;
        logic       outEnable;
        logic       captureSelect;
        logic [2:0] mode;
        logic       counterEnable;
    } ctrl_type;
    localparam int unsigned CTRL_W = $bits(ctrl_type);
    localparam ctrl_type CTRL_RESET = ctrl_type'(8'h00);

endpackage

// file: cc1_far_side.sv
// Far-side model: capture trigger source and output pin observer
module cc1_far_side (
    input  wire logic core_clk,
    output logic      captureInput,
    input  wire logic outputPin,
    output int        pinToggles
);
    timeunit 1ns;
    timeprecision 1ps;

    logic lastPin;

    // Idle low from time zero, so the first driven rise is a clean edge
    initial begin
        captureInput = 1'b0;
        pinToggles   = 0;
        lastPin      = 1'b0;
    end

    // Count level changes; an unknown pin before reset never counts
    always @(posedge core_clk) begin
        if ((outputPin ^ lastPin) === 1'b1) pinToggles <= pinToggles + 1;
        lastPin <= outputPin;
    end

    // New level right after an edge, held long enough for the sampler to see it
    task automatic drive(input logic lvl);
        @(posedge core_clk);
        captureInput <= lvl;
        repeat (3) @(posedge core_clk);
    endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the channel one capture/compare block
module tb_top
    import timer_cc1_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk, sys_rst, clkEn, countTick, captureInput, outputPin, matchInterrupt;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [AXI_W-1:0]  wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic [2:0]        prot;
    logic              awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int                n_mismatch, comparisons, matchCount, pinToggles, m0, p0;

    timer_channel_one_capture_compare dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .countTick(countTick),
        .captureInput(captureInput), .outputPin(outputPin), .matchInterrupt(matchInterrupt),
        .awaddr(awaddr), .awprot(prot), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(prot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    cc1_far_side farSide (
        .core_clk(core_clk), .captureInput(captureInput), .outputPin(outputPin), .pinToggles(pinToggles)
    );

    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Match pulses last one cycle, so count them at every edge
    always @(posedge core_clk)
        if (matchInterrupt === 1'b1) matchCount <= matchCount + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and bus tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Address and data offered together; each released at its own handshake
    task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone  = 1'b0;
        @(posedge core_clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge core_clk);
            if (!awDone && awready === 1'b1) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready === 1'b1) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic expectWrite(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                               input logic [3:0] s, input logic [1:0] er);
        logic [1:0] r;
        axiWrite(a, d, s, r);
        check(n, 32'(r), 32'(er));
    endtask

    task automatic expectRead(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] ed,
                              input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axiRead(a, d, r);
        check(n, d, ed);
        check(n, 32'(r), 32'(er));
    endtask

    // Stop the counter first so every scenario starts from the idle count
    task automatic restart(input logic [2:0] md, input logic cs, input logic oe, input logic [1:0] es);
        ctrl_type c;
        c = '{edgeSel: es, outEnable: oe, captureSelect: cs, mode: md, counterEnable: 1'b0};
        expectWrite("ctrlStop", ADDR_TIMER_CTRL, 32'(c), 4'hF, RESP_OKAY);
        expectRead("rbStopped", ADDR_COUNTER_RB, 32'h0000_0000, RESP_OKAY);
        c.counterEnable = 1'b1;
        expectWrite("ctrlRun", ADDR_TIMER_CTRL, 32'(c), 4'hF, RESP_OKAY);
    endtask

    // One count step per pair of edges; the extra edge lets a match pulse be counted
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            countTick <= 1'b1;
            @(posedge core_clk);
            countTick <= 1'b0;
        end
        @(posedge core_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios; the bench never touches the registers with the main clock stopped
    task automatic testReset();
        expectRead("ccReset", ADDR_CHANNEL_ONE_CC, 32'h0000_0000, RESP_OKAY);
        expectRead("rbReset", ADDR_COUNTER_RB, 32'h0000_0000, RESP_OKAY);
        expectRead("unmapped", 16'h0004, 32'h0000_0000, RESP_SLVERR);
    endtask

    task automatic testRefuse();
        expectWrite("rbWrite", ADDR_COUNTER_RB, 32'h0000_1111, 4'hF, RESP_SLVERR);
        expectWrite("ccHalf", ADDR_CHANNEL_ONE_CC, 32'h0000_2222, 4'h1, RESP_SLVERR);
        expectRead("ccKept", ADDR_CHANNEL_ONE_CC, 32'h0000_0000, RESP_OKAY);
        expectRead("rbKept", ADDR_COUNTER_RB, 32'h0000_0000, RESP_OKAY);
        expectWrite("ccFull", ADDR_CHANNEL_ONE_CC, 32'h0000_ABCD, 4'hF, RESP_OKAY);
        expectRead("ccFull", ADDR_CHANNEL_ONE_CC, 32'h0000_ABCD, RESP_OKAY);
    endtask

    task automatic testCompare();
        restart(MODE_INTERVAL, 1'b0, 1'b1, EDGE_BOTH);
        expectRead("rbIdle", ADDR_COUNTER_RB, 32'h0000_FFFF, RESP_OKAY);
        tick(1);
        expectRead("rbWrap", ADDR_COUNTER_RB, 32'h0000_0000, RESP_OKAY);
        expectWrite("ccRun", ADDR_CHANNEL_ONE_CC, 32'h0000_0003, 4'hF, RESP_OKAY);
        m0 = matchCount;
        p0 = pinToggles;
        tick(2);
        check("earlyMatch", 32'(matchCount), 32'(m0));
        tick(1);
        check("match", 32'(matchCount), 32'(m0 + 1));
        check("pinToggle", 32'(pinToggles), 32'(p0 + 1));
        check("pinLevel", 32'(outputPin), 32'h0000_0001);
        expectRead("rbLive", ADDR_COUNTER_RB, 32'h0000_0003, RESP_OKAY);
        farSide.drive(1'b1);
        farSide.drive(1'b0);
        expectRead("noCapture", ADDR_CHANNEL_ONE_CC, 32'h0000_0003, RESP_OKAY);
    endtask

    task automatic testBatch();
        restart(MODE_PWM, 1'b0, 1'b0, EDGE_NONE);
        expectWrite("ccPwm", ADDR_CHANNEL_ONE_CC, 32'h0000_0002, 4'hF, RESP_OKAY);
        tick(1);
        expectWrite("ccBatch", ADDR_CHANNEL_ONE_CC, 32'h0000_0006, 4'hF, RESP_OKAY);
        m0 = matchCount;
        p0 = pinToggles;
        tick(2);
        check("oldShadow", 32'(matchCount), 32'(m0 + 1));
        check("pinQuiet", 32'(pinToggles), 32'(p0));
        expectRead("ccReg", ADDR_CHANNEL_ONE_CC, 32'h0000_0006, RESP_OKAY);
    endtask

    task automatic testFreeRun();
        restart(MODE_FREERUN, 1'b1, 1'b0, EDGE_RISE);
        tick(5);
        farSide.drive(1'b1);
        expectRead("capRise", ADDR_CHANNEL_ONE_CC, 32'h0000_0004, RESP_OKAY);
        tick(2);
        farSide.drive(1'b0);
        expectRead("capFall", ADDR_CHANNEL_ONE_CC, 32'h0000_0004, RESP_OKAY);
        expectRead("rbFree", ADDR_COUNTER_RB, 32'h0000_0006, RESP_OKAY);
    endtask

    // Free-run with compare selected ignores the capture pin; a low enable freezes the count
    task automatic testFreeze();
        prot <= 3'h2;
        restart(MODE_FREERUN, 1'b0, 1'b1, EDGE_RISE);
        expectWrite("ccFreeCmp", ADDR_CHANNEL_ONE_CC, 32'h0000_0001, 4'hF, RESP_OKAY);
        m0 = matchCount;
        p0 = pinToggles;
        tick(2);
        check("freeMatch", 32'(matchCount), 32'(m0 + 1));
        check("freePin", 32'(pinToggles), 32'(p0 + 1));
        farSide.drive(1'b1);
        farSide.drive(1'b0);
        expectRead("freeNoCap", ADDR_CHANNEL_ONE_CC, 32'h0000_0001, RESP_OKAY);
        @(posedge core_clk);
        clkEn <= 1'b0;
        // No register access while the clock is held off
        tick(3);
        @(posedge core_clk);
        clkEn <= 1'b1;
        expectRead("rbFrozen", ADDR_COUNTER_RB, 32'h0000_0001, RESP_OKAY);
        prot <= 3'h0;
    endtask

    task automatic testPulseWidth();
        restart(MODE_PULSEW, 1'b0, 1'b0, EDGE_BOTH);
        tick(4);
        farSide.drive(1'b1);
        expectRead("capWidth", ADDR_CHANNEL_ONE_CC, 32'h0000_0003, RESP_OKAY);
        expectRead("rbCleared", ADDR_COUNTER_RB, 32'h0000_0000, RESP_OKAY);
        expectWrite("ccIgnored", ADDR_CHANNEL_ONE_CC, 32'h0000_0009, 4'hF, RESP_OKAY);
        expectRead("ccHeld", ADDR_CHANNEL_ONE_CC, 32'h0000_0003, RESP_OKAY);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence, with a second reset in mid-run
    initial begin
        {sys_rst, clkEn} = 2'b11;
        {countTick, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, prot} = '0;
        {n_mismatch, comparisons, matchCount} = '0;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        testReset();
        testRefuse();
        testCompare();
        testBatch();
        testFreeRun();
        testFreeze();
        testPulseWidth();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        testReset();
        summarize();
    end

    // A hung handshake ends the run here instead of spinning forever
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        summarize();
    end
endmodule
